// file: fbp_flash_host.sv
// Host controller that drives flash block-protection command sequences from APB
//Contract
//- A mode stays entered until its matching exit; host tracks it.
//- Register and password reads are plain read cycles with CE and OE low.
//- Password is programmed word by word at consecutive password addresses.
//- Password portions may move in any order if all 64 bits move.
//- Unlock ends at cycle 11 (x8) or 7 (x16); password read at 8 or 4.
//- Unlock attempts are spaced by at least 6 us; earlier ones are refused.
module fbp_flash_host
    import fbp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_byte_n,
    output logic [ADDR_W-2:0] flash_addr,
    output logic byte_select_line,
    output logic [DQ_W-1:0] flash_dq_out,
    input wire logic [DQ_W-1:0] flash_dq_in,
    output logic flash_dq_oe_n
);
    logic [ADDR_W-1:0] addr_reg;
    logic [DQ_W-1:0] data_reg;
    logic byte_mode;
    logic [63:0] pwd;
    logic [DQ_W-1:0] rdata;
    logic err;
    fbp_mode_e mode;
    fbp_state_e state;
    logic [3:0] op_q;
    logic [3:0] idx;
    logic [7:0] cnt;
    logic [9:0] unl_wait;
    fbp_step_s step;
    logic [DQ_W-1:0] dq_s1;
    logic [DQ_W-1:0] dq_s2;
    logic apb_acc;
    logic apb_wr;
    logic start_req;
    logic start_ok;
    logic seq_done;
    logic capture;

    // Password byte or word k of the 64-bit value
    function automatic logic [DQ_W-1:0] pwd_part(input logic [63:0] p, input logic bm, input logic [3:0] k);
        pwd_part = bm ? {8'h00, p[8*k[2:0] +: 8]} : p[16*k[1:0] +: 16];
    endfunction : pwd_part

    // Number of password portions: eight bytes or four words
    function automatic logic [3:0] pwd_cnt(input logic bm);
        pwd_cnt = bm ? 4'd8 : 4'd4;
    endfunction : pwd_cnt

    // Mode that an entry code selects; unknown codes map to read
    function automatic fbp_mode_e code_mode(input logic [7:0] c);
        case (c)
            ENT_LOCKREG: code_mode = MD_LOCKREG;
            ENT_PWD: code_mode = MD_PWD;
            ENT_NV: code_mode = MD_NV;
            ENT_LOCKBIT: code_mode = MD_LOCKBIT;
            ENT_VOL: code_mode = MD_VOL;
            ENT_EXT: code_mode = MD_EXT;
            default: code_mode = MD_READ;
        endcase
    endfunction : code_mode

    // Whether an operation is defined in the current mode
    function automatic logic op_legal(input logic [3:0] o, input fbp_mode_e m, input logic [7:0] c,
                                      input logic waiting);
        case (o)
            OP_ENTER: op_legal = (m == MD_READ) && (code_mode(c) != MD_READ);
            OP_EXIT_PROT: op_legal = (m != MD_READ) && (m != MD_EXT);
            OP_EXIT_EXT: op_legal = (m == MD_EXT);
            OP_PROGRAM: op_legal = (m != MD_READ) && (m != MD_EXT);
            OP_PROGRAM_EXT: op_legal = (m == MD_EXT);
            OP_CLEAR_ALL: op_legal = (m == MD_NV);
            OP_READ: op_legal = 1'b1;
            OP_READ_PWD: op_legal = (m == MD_PWD);
            OP_UNLOCK: op_legal = (m == MD_PWD) && !waiting;
            default: op_legal = 1'b0;
        endcase
    endfunction : op_legal

    // Address, data and direction of bus cycle i of operation o
    function automatic fbp_step_s seq_step(input logic [3:0] o, input logic [3:0] i, input logic bm,
                                           input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d,
                                           input logic [63:0] p);
        logic [ADDR_W-1:0] u1;
        logic [ADDR_W-1:0] u2;
        logic [3:0] n;
        u1 = bm ? UA1_X8 : UA1_X16;
        u2 = bm ? UA2_X8 : UA2_X16;
        n = pwd_cnt(bm);
        seq_step = '0;
        case (o)
            OP_ENTER, OP_EXIT_EXT, OP_PROGRAM_EXT: begin
                case (i)
                    4'd0: seq_step = '{1'b0, 1'b0, u1, CMD_AA};
                    4'd1: seq_step = '{1'b0, 1'b0, u2, CMD_55};
                    4'd2: begin
                        if (o == OP_ENTER) begin
                            seq_step = '{1'b0, 1'b1, u1, {8'h00, d[7:0]}};
                        end else if (o == OP_EXIT_EXT) begin
                            seq_step = '{1'b0, 1'b0, EXT_EXIT_A3, CMD_EXIT1};
                        end else begin
                            seq_step = '{1'b0, 1'b0, u1, CMD_PROG};
                        end
                    end
                    default: seq_step = (o == OP_EXIT_EXT) ? fbp_step_s'{1'b0, 1'b1, '0, CMD_EXIT2}
                                                           : fbp_step_s'{1'b0, 1'b1, a, d};
                endcase
            end
            OP_EXIT_PROT: seq_step = (i == 4'd0) ? fbp_step_s'{1'b0, 1'b0, '0, CMD_EXIT1}
                                                 : fbp_step_s'{1'b0, 1'b1, '0, CMD_EXIT2};
            OP_PROGRAM: seq_step = (i == 4'd0) ? fbp_step_s'{1'b0, 1'b0, '0, CMD_PROG}
                                               : fbp_step_s'{1'b0, 1'b1, a, d};
            OP_CLEAR_ALL: seq_step = (i == 4'd0) ? fbp_step_s'{1'b0, 1'b0, '0, CMD_CLR1}
                                                 : fbp_step_s'{1'b0, 1'b1, '0, CMD_CLR2};
            OP_READ: seq_step = '{1'b1, 1'b1, a, '0};
            OP_READ_PWD: seq_step = '{1'b1, i == n - 4'd1, ADDR_W'(i), '0};
            OP_UNLOCK: begin
                if (i == 4'd0) begin
                    seq_step = '{1'b0, 1'b0, '0, CMD_UNL1};
                end else if (i == 4'd1) begin
                    seq_step = '{1'b0, 1'b0, '0, CMD_UNL2};
                end else if (i < n + 4'd2) begin
                    seq_step = '{1'b0, 1'b0, ADDR_W'(i - 4'd2), pwd_part(p, bm, i - 4'd2)};
                end else begin
                    seq_step = '{1'b0, 1'b1, '0, CMD_UNL_END};
                end
            end
            default: seq_step = '{1'b0, 1'b1, '0, '0};
        endcase
    endfunction : seq_step

    assign apb_acc = psel && penable && pready;
    assign apb_wr = apb_acc && pwrite;
    assign start_req = apb_wr && (paddr == REG_CTRL);
    assign start_ok = start_req && (state == ST_IDLE) &&
                      op_legal(pwdata[CTRL_OP_LSB +: 4], mode, data_reg[7:0], unl_wait != '0);
    assign step = seq_step(op_q, idx, byte_mode, addr_reg, data_reg, pwd);
    assign seq_done = (state == ST_RECOVER) && (cnt == 8'd1) && step.last;
    assign capture = (state == ST_STROBE) && (cnt == 8'd1) && step.rd;

    // Two-flop synchroniser on the data pins; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            dq_s1 <= flash_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    // APB answer: one wait state, so every access completes on its second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && (paddr > REG_RDATA || paddr[1:0] != 2'b00);
            prdata <= '0;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    REG_ADDR: prdata <= 32'(addr_reg);
                    REG_DATA: prdata <= 32'(data_reg);
                    REG_CFG: prdata <= 32'(byte_mode);
                    REG_PWD_LO: prdata <= pwd[31:0];
                    REG_PWD_HI: prdata <= pwd[63:32];
                    REG_STATUS: prdata <= {25'h0, mode, 1'b0, unl_wait != '0, err, state != ST_IDLE};
                    REG_RDATA: prdata <= 32'(rdata);
                    default: prdata <= '0;
                endcase
            end
        end
    end

    // Software-owned settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= '0;
            data_reg <= '0;
            byte_mode <= 1'b0;
            flash_byte_n <= 1'b1;
        end else if (apb_wr) begin
            if (paddr == REG_ADDR) addr_reg <= pwdata[ADDR_W-1:0];
            if (paddr == REG_DATA) data_reg <= pwdata[DQ_W-1:0];
            if (paddr == REG_CFG) begin
                byte_mode <= pwdata[CFG_BYTE_BIT];
                flash_byte_n <= !pwdata[CFG_BYTE_BIT]; // Pin has its own flop, no gate after it
            end
        end
    end

    // Password holding register: software fills it, a password read refills it portion by portion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwd <= '1;
        end else if (capture && op_q == OP_READ_PWD) begin
            if (byte_mode) begin
                pwd[8*idx[2:0] +: 8] <= dq_s2[7:0];
            end else begin
                pwd[16*idx[1:0] +: 16] <= dq_s2;
            end
        end else if (apb_wr && paddr == REG_PWD_LO) begin
            pwd[31:0] <= pwdata;
        end else if (apb_wr && paddr == REG_PWD_HI) begin
            pwd[63:32] <= pwdata;
        end
    end

    // Sticky error: a refused start sets it, writing one clears it; the set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err <= 1'b0;
        end else if (start_req && !start_ok) begin
            err <= 1'b1;
        end else if (apb_wr && paddr == REG_STATUS && pwdata[ST_ERR_BIT]) begin
            err <= 1'b0;
        end
    end

    // Mode tracking; only a finished entry or exit sequence moves it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MD_READ;
        end else if (seq_done) begin
            if (op_q == OP_ENTER) mode <= code_mode(data_reg[7:0]);
            if (op_q == OP_EXIT_PROT || op_q == OP_EXIT_EXT) mode <= MD_READ;
        end
    end

    // Spacing after an unlock; also covers the device's own unlock time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unl_wait <= '0;
        end else if (seq_done && op_q == OP_UNLOCK) begin
            unl_wait <= UNLOCK_CYC;
        end else if (unl_wait != '0) begin
            unl_wait <= unl_wait - 10'd1;
        end
    end

    // Bus-cycle sequencer: setup, strobe, recovery for each step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            op_q <= '0;
            idx <= '0;
            cnt <= '0;
            rdata <= '0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_dq_oe_n <= 1'b1;
            flash_addr <= '0;
            byte_select_line <= 1'b0;
            flash_dq_out <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_ok) begin
                        op_q <= pwdata[CTRL_OP_LSB +: 4];
                        idx <= '0;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    flash_addr <= byte_mode ? step.a[ADDR_W-1:1] : step.a[ADDR_W-2:0];
                    byte_select_line <= byte_mode & step.a[0];
                    flash_dq_out <= {8'h00, step.d[7:0]} | (op_q == OP_READ || step.rd ? '0 : step.d & 16'hff00);
                    flash_dq_oe_n <= step.rd;
                    flash_ce_n <= 1'b0;
                    cnt <= (step.rd ? ACC_CYC : WE_CYC) + 8'd1;
                    state <= ST_STROBE;
                end
                ST_STROBE: begin
                    cnt <= cnt - 8'd1;
                    flash_we_n <= step.rd || (cnt == 8'd1);
                    flash_oe_n <= !step.rd || (cnt == 8'd1);
                    if (capture && op_q == OP_READ) rdata <= dq_s2;
                    if (cnt == 8'd1) begin
                        cnt <= REC_CYC;
                        state <= ST_RECOVER;
                    end
                end
                ST_RECOVER: begin
                    cnt <= cnt - 8'd1;
                    if (cnt == 8'd1) begin
                        flash_ce_n <= 1'b1;
                        flash_dq_oe_n <= 1'b1;
                        idx <= idx + 4'd1;
                        state <= step.last ? ST_IDLE : ST_SETUP;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Helper: cycles since the last unlock finished, saturating; independent of unl_wait
    logic [9:0] unl_gap;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unl_gap <= '1;
        end else if (seq_done && op_q == OP_UNLOCK) begin
            unl_gap <= '0;
        end else if (unl_gap != '1) begin
            unl_gap <= unl_gap + 10'd1;
        end
    end

    sequence s_we_pulse;
        !flash_we_n [*5] ##1 flash_we_n;
    endsequence

    sequence s_exit_done;
        seq_done && (op_q == OP_EXIT_PROT || op_q == OP_EXIT_EXT);
    endsequence

    AST_STROBE_EXCL: assert property (@(posedge pclk) disable iff (!presetn)
        !(!flash_we_n && !flash_oe_n)) else $error("write and read strobes low together");
    AST_STROBE_CE: assert property (@(posedge pclk) disable iff (!presetn)
        (!flash_we_n || !flash_oe_n) |-> !flash_ce_n) else $error("strobe without chip enable");
    AST_READ_NO_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
        !flash_oe_n |-> flash_dq_oe_n) else $error("data driven during read");
    AST_WE_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(flash_we_n) |-> s_we_pulse) else $error("write pulse width wrong");
    AST_EXIT_READ: assert property (@(posedge pclk) disable iff (!presetn)
        s_exit_done |=> mode == MD_READ) else $error("exit did not return to read mode");
    AST_MODE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !seq_done |=> $stable(mode)) else $error("mode changed without a finished sequence");
    AST_REFUSE_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        (start_req && !start_ok) |=> err && $stable(op_q)) else $error("refused start not flagged");
    AST_UNLOCK_SPACE: assert property (@(posedge pclk) disable iff (!presetn)
        (start_ok && pwdata[CTRL_OP_LSB +: 4] == OP_UNLOCK) |-> unl_gap >= UNLOCK_CYC)
        else $error("unlock spacing wrong");
    AST_UNLOCK_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
        (unl_gap < UNLOCK_CYC) |-> unl_wait != '0) else $error("unlock spacing flag dropped early");
    AST_UNLOCK_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        (seq_done && op_q == OP_UNLOCK) |-> idx == pwd_cnt(byte_mode) + 4'd2) else $error("unlock length wrong");
    AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready) else $error("APB answer late");
endmodule : fbp_flash_host

// file: fbp_flash_model.sv
// Behavioural block-protection flash device (x16 bus) facing the host controller
module fbp_flash_model
    import fbp_pkg::*;
(
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [ADDR_W-2:0] addr,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    fbp_mode_e mode = MD_READ;
    logic [15:0] qd[$];
    logic [63:0] pwd = '1;
    logic [15:0] lreg = 16'hffff, last = 16'h0, ext[128] = '{default: 16'hffff};
    logic nv[4] = '{default: 1'b1}, vl[4] = '{default: 1'b1}, lockb = 1'b1;
    realtime t_unl = -1.0e9;
    // Cycles are taken at the rising write strobe; codes live in the low byte only
    always @(posedge we_n) if (!ce_n) begin
        qd.push_back(dq_in);
        if (qd[0][7:0] == 8'haa && qd.size() == 3 && mode == MD_READ) begin
            case (qd[2][7:0])
                8'h40: mode = MD_LOCKREG;
                8'h60: mode = MD_PWD;
                8'hc0: mode = MD_NV;
                8'h50: mode = MD_LOCKBIT;
                8'he0: mode = MD_VOL;
                8'h88: mode = MD_EXT;
                default: ;
            endcase
            qd = {};
        end else if (qd[0][7:0] == 8'haa && qd.size() == 4 && mode == MD_EXT) begin
            if (qd[2][7:0] == 8'h90) mode = MD_READ;
            else if (lreg[0]) ext[addr[6:0]] &= dq_in;
            qd = {};
        end else if (qd[0][7:0] == 8'h90 && qd.size() == 2) begin
            if (mode != MD_EXT) mode = MD_READ;
            qd = {};
        end else if (qd[0][7:0] == 8'ha0 && qd.size() == 2) begin
            case (mode)
                MD_LOCKREG: lreg = dq_in;
                MD_PWD: pwd[16*addr[1:0] +: 16] = dq_in;
                MD_NV: nv[addr[17:16]] = 1'b0;
                MD_LOCKBIT: lockb = 1'b0;
                MD_VOL: vl[addr[17:16]] = dq_in[0];
                default: ;
            endcase
            qd = {};
        end else if (qd[0][7:0] == 8'h80 && qd.size() == 2) begin
            if (lockb && mode == MD_NV) nv = '{default: 1'b1};
            qd = {};
        end else if (qd[0][7:0] == 8'h25 && qd.size() == 7) begin
            // Too-early attempts are dropped so guessing stays slow
            if (mode == MD_PWD && $realtime - t_unl >= 6000.0 && {qd[5], qd[4], qd[3], qd[2]} == pwd) lockb = 1'b1;
            t_unl = $realtime;
            qd = {};
        end else if (!(qd[0][7:0] inside {8'haa, 8'h90, 8'ha0, 8'h80, 8'h25}) || qd.size() > 7) qd = {};
    end
    // Read data follows the mode; a released bus shows the inverse of its last value
    always @* begin
        if (!ce_n && !oe_n) begin
            case (mode)
                MD_LOCKREG: dq_out = lreg;
                MD_PWD: dq_out = pwd[16*addr[1:0] +: 16];
                MD_NV: dq_out = {15'h0, nv[addr[17:16]]};
                MD_LOCKBIT: dq_out = {15'h0, lockb};
                MD_VOL: dq_out = {15'h0, vl[addr[17:16]]};
                MD_EXT: dq_out = ext[addr[6:0]];
                default: dq_out = addr[15:0] ^ 16'h5a5a;
            endcase
            last = dq_out;
        end else dq_out = ~last;
    end
endmodule : fbp_flash_model

// file: fbp_pkg.sv
// Package for the flash block-protection host: map, codes, timing and carriers
package fbp_pkg;
    localparam int ADDR_W = 26;
    localparam int DQ_W = 16;
    // APB register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_CFG = 8'h0c;
    localparam logic [7:0] REG_PWD_LO = 8'h10;
    localparam logic [7:0] REG_PWD_HI = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_RDATA = 8'h1c;
    // Field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int CFG_BYTE_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ERR_BIT = 1;
    localparam int ST_WAIT_BIT = 2;
    localparam int ST_MODE_LSB = 4;
    // Operation codes written to CTRL
    localparam logic [3:0] OP_ENTER = 4'h1;
    localparam logic [3:0] OP_EXIT_PROT = 4'h2;
    localparam logic [3:0] OP_EXIT_EXT = 4'h3;
    localparam logic [3:0] OP_PROGRAM = 4'h4;
    localparam logic [3:0] OP_PROGRAM_EXT = 4'h5;
    localparam logic [3:0] OP_CLEAR_ALL = 4'h6;
    localparam logic [3:0] OP_READ = 4'h7;
    localparam logic [3:0] OP_READ_PWD = 4'h8;
    localparam logic [3:0] OP_UNLOCK = 4'h9;
    // Flash command bytes and unlock addresses
    localparam logic [15:0] CMD_AA = 16'h00aa;
    localparam logic [15:0] CMD_55 = 16'h0055;
    localparam logic [15:0] CMD_PROG = 16'h00a0;
    localparam logic [15:0] CMD_EXIT1 = 16'h0090;
    localparam logic [15:0] CMD_EXIT2 = 16'h0000;
    localparam logic [15:0] CMD_CLR1 = 16'h0080;
    localparam logic [15:0] CMD_CLR2 = 16'h0030;
    localparam logic [15:0] CMD_UNL1 = 16'h0025;
    localparam logic [15:0] CMD_UNL2 = 16'h0003;
    localparam logic [15:0] CMD_UNL_END = 16'h0029;
    localparam logic [7:0] ENT_LOCKREG = 8'h40;
    localparam logic [7:0] ENT_PWD = 8'h60;
    localparam logic [7:0] ENT_NV = 8'hc0;
    localparam logic [7:0] ENT_LOCKBIT = 8'h50;
    localparam logic [7:0] ENT_VOL = 8'he0;
    localparam logic [7:0] ENT_EXT = 8'h88;
    localparam logic [ADDR_W-1:0] UA1_X16 = 26'h555;
    localparam logic [ADDR_W-1:0] UA2_X16 = 26'h2aa;
    localparam logic [ADDR_W-1:0] UA1_X8 = 26'haaa;
    localparam logic [ADDR_W-1:0] UA2_X8 = 26'h555;
    localparam logic [ADDR_W-1:0] EXT_EXIT_A3 = 26'h555;
    // Timing: figures in ns, counts in cycles of pclk
    localparam int CLK_NS = 8;
    localparam int T_WE_NS = 40;
    localparam int T_ACC_NS = 110;
    localparam int T_REC_NS = 20;
    localparam int T_UNLOCK_NS = 6000;
    localparam int SYNC_CYC = 2;
    localparam logic [7:0] WE_CYC = 8'((T_WE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
    localparam logic [7:0] REC_CYC = 8'((T_REC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] UNLOCK_CYC = 10'((T_UNLOCK_NS + CLK_NS - 1) / CLK_NS);
    typedef enum logic [2:0] {MD_READ, MD_LOCKREG, MD_PWD, MD_NV, MD_LOCKBIT, MD_VOL, MD_EXT} fbp_mode_e;
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} fbp_state_e;
    // One flash bus cycle of a command sequence
    typedef struct packed {
        logic rd;
        logic last;
        logic [ADDR_W-1:0] a;
        logic [DQ_W-1:0] d;
    } fbp_step_s;
endpackage : fbp_pkg

// file: tb_fbp_flash_host.sv
// Self-checking bench for the flash block-protection host
module tb_fbp_flash_host
    import fbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, ce_n, oe_n, we_n, dq_oe_n, byte_n, bsl;
    logic [ADDR_W-2:0] fa;
    logic [DQ_W-1:0] dq_o, dq_m, dq_w, v;
    logic [63:0] exp_pwd;
    int n_fail = 0, samples_checked = 0, cyc = 0, seed = 32'h43717ab6;
    assign dq_w = dq_oe_n ? dq_m : dq_o;
    fbp_flash_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_byte_n(byte_n), .flash_addr(fa), .byte_select_line(bsl),
        .flash_dq_out(dq_o), .flash_dq_in(dq_w), .flash_dq_oe_n(dq_oe_n));
    fbp_flash_model i_dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .dq_in(dq_w), .dq_out(dq_m));
    // 125 MHz clock and a cycle ceiling against hangs
    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
        samples_checked++;
        if (seen !== x) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, x, seen);
        end
    endtask : chk
    // One APB transfer; the idle edge at the end keeps psel from toggling twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic op(input logic [3:0] o, input logic [25:0] a, input logic [15:0] d);
        apb(1'b1, REG_ADDR, 32'(a));
        apb(1'b1, REG_DATA, 32'(d));
        apb(1'b1, REG_CTRL, 32'(o));
        apb(1'b0, REG_STATUS, 32'h0);
        while (r[ST_BUSY_BIT] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0);
    endtask : op
    task automatic rd(input string nm, input logic [25:0] a, input logic [31:0] x);
        op(OP_READ, a, 16'h0);
        apb(1'b0, REG_RDATA, 32'h0);
        chk(nm, r, x);
    endtask : rd
    task automatic st(input logic [2:0] m, input logic er);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'({r[ST_MODE_LSB +: 3], r[ST_ERR_BIT]}), 32'({m, er}));
        apb(1'b1, REG_STATUS, 32'h2);
    endtask : st
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // Main sequence: x16 bus then one x8 read; every mode entered and left at least once (NV and lock bit twice)
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_PWD_LO, 32'h0);
        chk("pwd_reset", r, 32'hffffffff);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", {r[30:0], e}, 32'h1);
        op(OP_ENTER, 26'h0, 16'(ENT_NV));
        st(MD_NV, 1'b0);
        rd("nv_free", 26'h10000, 32'h1);
        op(OP_PROGRAM, 26'h10000, 16'h0);
        rd("nv_set", 26'h10000, 32'h0);
        rd("nv_other", 26'h20000, 32'h1);
        op(OP_CLEAR_ALL, 26'h0, 16'h0);
        rd("nv_clr", 26'h10000, 32'h1);
        op(OP_EXIT_PROT, 26'h0, 16'h0);
        st(MD_READ, 1'b0);
        op(OP_ENTER, 26'h0, 16'(ENT_VOL));
        for (int i = 0; i < 2; i++) begin
            op(OP_PROGRAM, 26'h20000, 16'(i));
            rd("vol", 26'h20000, 32'(i));
        end
        op(OP_EXIT_PROT, 26'h0, 16'h0);
        $display("test nv_vol done");
        op(OP_ENTER, 26'h0, 16'(ENT_LOCKBIT));
        op(OP_PROGRAM, 26'h0, 16'h0);
        rd("lockbit", 26'h0, 32'h0);
        op(OP_EXIT_PROT, 26'h0, 16'h0);
        op(OP_ENTER, 26'h0, 16'(ENT_NV));
        op(OP_PROGRAM, 26'h30000, 16'h0);
        op(OP_CLEAR_ALL, 26'h0, 16'h0);
        rd("nv_frozen", 26'h30000, 32'h0);
        op(OP_EXIT_PROT, 26'h0, 16'h0);
        op(OP_CLEAR_ALL, 26'h0, 16'h0);
        st(MD_READ, 1'b1);
        $display("test lockbit done");
        op(OP_ENTER, 26'h0, 16'(ENT_PWD));
        exp_pwd = {$random(seed), $random(seed)};
        for (int i = 3; i >= 0; i--) op(OP_PROGRAM, 26'(i), exp_pwd[16*i +: 16]);
        apb(1'b1, REG_PWD_LO, 32'h0);
        op(OP_READ_PWD, 26'h0, 16'h0);
        apb(1'b0, REG_PWD_LO, 32'h0);
        chk("pwd_lo", r, exp_pwd[31:0]);
        apb(1'b0, REG_PWD_HI, 32'h0);
        chk("pwd_hi", r, exp_pwd[63:32]);
        op(OP_UNLOCK, 26'h0, 16'h0);
        op(OP_UNLOCK, 26'h0, 16'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("spacing", 32'(r[2:1]), 32'h3);
        st(MD_PWD, 1'b1);
        op(OP_EXIT_PROT, 26'h0, 16'h0);
        op(OP_ENTER, 26'h0, 16'(ENT_LOCKBIT));
        rd("unlocked", 26'h0, 32'h1);
        op(OP_EXIT_PROT, 26'h0, 16'h0);
        $display("test password done");
        v = 16'($random(seed)) | 16'h0001;
        op(OP_ENTER, 26'h0, 16'(ENT_LOCKREG));
        op(OP_PROGRAM, 26'h0, v);
        rd("lockreg", 26'h0, 32'(v));
        op(OP_EXIT_PROT, 26'h0, 16'h0);
        op(OP_ENTER, 26'h0, 16'(ENT_EXT));
        op(OP_PROGRAM_EXT, 26'h5, v);
        rd("ext", 26'h5, 32'(v));
        op(OP_PROGRAM_EXT, 26'h5, 16'hffff);
        rd("ext_once", 26'h5, 32'(v));
        op(OP_ENTER, 26'h0, 16'(ENT_NV));
        st(MD_EXT, 1'b1);
        op(OP_EXIT_EXT, 26'h0, 16'h0);
        st(MD_READ, 1'b0);
        $display("test lockreg_ext done");
        apb(1'b1, REG_CFG, 32'h1);
        rd("x8_read", 26'h3, 32'h5a5b);
        chk("x8_pins", 32'({byte_n, bsl}), 32'h1);
        $display("test byte_mode done");
        end_sim();
    end
endmodule : tb_fbp_flash_host
